// [sar_conv_ctrl.sv]
/*
  Conversion control: serial frame logic on sclk, scan sequencing and result FIFO on clk.
  Assumes an analog front end that returns a signed difference in LSBs, held steady
  while sample_o's conversion runs, and a host that leaves 3 clk periods after a
  chip-select fall before the first sclk fall.
*/
`timescale 1ns/1ns
module sar_conv_ctrl
  import sar_conv_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               sclk_i,
  input  wire logic               cs_n_i,
  input  wire logic               din_i,
  input  wire logic               convert_start_n_i,
  input  wire logic signed [12:0] conv_diff_i,
  output logic                    dout_o,
  output logic                    dout_oe_o,
  output logic                    eoc_n_o,
  output logic                    sample_o,
  output logic [3:0]              sample_ch_o,
  output in_mode_e                sample_mode_o,
  output logic [4:0]              fifo_count_o
);
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_CONV = 3'b100} state_e;

  // serial side
  logic        frame_rst_n;
  logic [4:0]  in_cnt;
  logic [14:0] in_shift;
  logic [15:0] word_hold;
  logic        word_tgl;
  logic [4:0]  out_cnt;
  logic [15:0] out_shift;
  logic        pop_tgl;
  // system side
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  sync3;
  logic        cs_fall, cs_rise, cnv_fall, word_evt, pop_evt, framing;
  logic        mode_wr, cfg_wr, uni_wr, bip_wr, soft_rst, fifo_rst;
  cfg_s        cfg;
  logic        external;
  logic        echo_pend;
  logic [15:0] echo_word;
  state_e      state;
  logic [7:0]  cnt, conv_age;
  logic        conv_ext, conv_end, scan_done, sw_run;
  result_s     res;
  logic [15:0] ext_word;
  logic        ext_valid;
  result_s     mem [FIFO_DEPTH];
  logic [3:0]  wr_ptr, rd_ptr;
  logic        do_wr, do_pop, ovw;
  logic [15:0] head;
  src_e        head_src;

  assign frame_rst_n = rst_n_i & ~cs_n_i;

  // input shifts on rising sclk; a high chip select clears the frame counters
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      in_cnt   <= 5'h00;
      in_shift <= 15'h0000;
    end else if (in_cnt != BIT_DONE) begin
      in_cnt   <= in_cnt + 5'h01;
      in_shift <= {in_shift[13:0], din_i};
    end
  end

  // held word lives past the frame so the system side can take it after the toggle
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_hold <= WORD_ZERO;
      word_tgl  <= 1'b0;
    end else if (in_cnt == BIT_LAST && frame_rst_n) begin
      word_hold <= {in_shift, din_i};
      word_tgl  <= ~word_tgl;
    end
  end

  // output shifts on falling sclk; first fall presents the word's top bit
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_cnt   <= 5'h00;
      out_shift <= WORD_ZERO;
      dout_o    <= 1'b0;
      dout_oe_o <= 1'b0;
    end else begin
      dout_oe_o <= 1'b1;
      if (out_cnt == 5'h00) begin
        dout_o    <= head[WORD_W-1];
        out_shift <= {head[WORD_W-2:0], 1'b0};
      end else begin
        dout_o    <= out_shift[WORD_W-1];
        out_shift <= {out_shift[WORD_W-2:0], 1'b0};
      end
      if (out_cnt != BIT_DONE) out_cnt <= out_cnt + 5'h01;
    end
  end

  // a short frame never toggles, so unread results stay put
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) pop_tgl <= 1'b0;
    else if (out_cnt == BIT_LAST && frame_rst_n) pop_tgl <= ~pop_tgl;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync3 <= SYNC_RST;
    end else begin
      sync1 <= {cs_n_i, convert_start_n_i, word_tgl, pop_tgl};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign cs_fall  = sync3[3] & ~sync2[3];
  assign cs_rise  = ~sync3[3] & sync2[3];
  assign cnv_fall = sync3[2] & ~sync2[2];
  assign word_evt = sync3[1] ^ sync2[1];
  assign pop_evt  = sync3[0] ^ sync2[0];
  assign framing  = ~sync2[3];

  assign mode_wr  = word_evt & ~word_hold[REG_SEL_BIT];
  assign cfg_wr   = word_evt & word_hold[REG_SEL_BIT] & (word_hold[14:11] == ID_CFG);
  assign uni_wr   = word_evt & word_hold[REG_SEL_BIT] & (word_hold[14:11] == ID_UNI);
  assign bip_wr   = word_evt & word_hold[REG_SEL_BIT] & (word_hold[14:11] == ID_BIP);
  assign soft_rst = mode_wr & (word_hold[6:5] == RST_ALL);
  assign fifo_rst = mode_wr & ((word_hold[6:5] == RST_FIFO) | (word_hold[6:5] == RST_ALL));
  assign external = (cfg.scan == SCAN_MANUAL);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= CFG_RST;
    end else begin
      if (scan_done && sw_run) cfg.software_convert <= 1'b0;
      if (mode_wr) begin
        cfg.scan    <= word_hold[14:11];
        cfg.last_ch <= word_hold[10:7];
        cfg.tag     <= word_hold[TAG_BIT];
        cfg.software_convert   <= word_hold[SOFTWARE_CONVERT_BIT];
      end
      if (uni_wr) begin
        cfg.uni   <= word_hold[10:3];
        cfg.pdiff <= word_hold[PDIFF_BIT];
      end
      if (bip_wr) cfg.bip <= word_hold[10:3];
      if (soft_rst) cfg <= CFG_RST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      echo_pend <= 1'b0;
      echo_word <= WORD_ZERO;
    end else begin
      if (pop_evt && head_src == SRC_ECHO) echo_pend <= 1'b0;
      if (cfg_wr && word_hold[ECHO_BIT]) begin
        echo_pend <= 1'b1;
        echo_word <= word_hold;
      end
    end
  end

  assign conv_end  = (state == ST_CONV) && (cnt == 8'h00);
  assign scan_done = conv_end && (conv_ext || sample_ch_o == cfg.last_ch);
  assign res       = '{ch: sample_ch_o, code: code_of(conv_diff_i, sample_mode_o)};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state         <= ST_IDLE;
      cnt           <= 8'h00;
      conv_ext      <= 1'b0;
      sw_run        <= 1'b0;
      sample_o      <= 1'b0;
      sample_ch_o   <= 4'h0;
      sample_mode_o <= IN_SE;
    end else begin
      sample_o <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (external && cs_fall) begin
            state         <= ST_CONV;
            cnt           <= CONV_CYC;
            conv_ext      <= 1'b1;
            sample_o      <= 1'b1;
            sample_ch_o   <= cfg.last_ch;
            sample_mode_o <= in_mode(cfg.last_ch, cfg);
          end else if (!external && cnv_fall && !framing) begin
            state         <= ST_CONV;
            cnt           <= CONV_CYC;
            conv_ext      <= 1'b0;
            sw_run        <= 1'b0;
            sample_o      <= 1'b1;
            sample_ch_o   <= 4'h0;
            sample_mode_o <= in_mode(4'h0, cfg);
          end else if (!external && cs_rise && cfg.software_convert) begin
            state  <= ST_WAIT;
            cnt    <= SW_DLY_CYC;
            sw_run <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (cnt == 8'h00) begin
            state         <= ST_CONV;
            cnt           <= CONV_CYC;
            conv_ext      <= 1'b0;
            sample_o      <= 1'b1;
            sample_ch_o   <= 4'h0;
            sample_mode_o <= in_mode(4'h0, cfg);
          end else cnt <= cnt - 8'h01;
        end
        ST_CONV: begin
          if (scan_done) begin
            state <= ST_IDLE;
          end else if (conv_end) begin
            cnt           <= CONV_CYC;
            sample_o      <= 1'b1;
            sample_ch_o   <= sample_ch_o + 4'h1;
            sample_mode_o <= in_mode(sample_ch_o + 4'h1, cfg);
          end else cnt <= cnt - 8'h01;
        end
        default: state <= ST_IDLE;
      endcase
      if (soft_rst) state <= ST_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) eoc_n_o <= 1'b1;
    else if (scan_done && !conv_ext) eoc_n_o <= 1'b0;
    else if (cs_fall || cnv_fall) eoc_n_o <= 1'b1;
  end

  // external results: tagged or with a leading zero and three trailing zeros
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_valid <= 1'b0;
      ext_word  <= WORD_ZERO;
    end else begin
      if (pop_evt && head_src == SRC_EXT) ext_valid <= 1'b0;
      if (conv_end && conv_ext) begin
        ext_valid <= 1'b1;
        ext_word  <= cfg.tag ? res : {1'b0, res.code, 3'b000};
      end
    end
  end

  assign do_wr  = conv_end & ~conv_ext;
  assign do_pop = pop_evt & (head_src == SRC_FIFO) & (fifo_count_o != 5'h00);
  assign ovw    = do_wr & (fifo_count_o == FIFO_FULL) & ~do_pop;

  always_ff @(posedge clk_i) begin
    if (do_wr) mem[wr_ptr] <= res;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr       <= 4'h0;
      rd_ptr       <= 4'h0;
      fifo_count_o <= 5'h00;
    end else if (fifo_rst) begin
      wr_ptr       <= 4'h0;
      rd_ptr       <= 4'h0;
      fifo_count_o <= 5'h00;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 4'h1;
      if (do_pop || ovw) rd_ptr <= rd_ptr + 4'h1;
      fifo_count_o <= fifo_count_o + {4'h0, do_wr} - {4'h0, do_pop} - {4'h0, ovw};
    end
  end

  // frozen while framing so the serial side reads a stable word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head     <= WORD_ZERO;
      head_src <= SRC_NONE;
    end else if (!framing) begin
      if (echo_pend) begin
        head     <= echo_word;
        head_src <= SRC_ECHO;
      end else if (external) begin
        head     <= ext_valid ? ext_word : WORD_ZERO;
        head_src <= SRC_EXT;
      end else begin
        head     <= (fifo_count_o != 5'h00) ? mem[rd_ptr] : WORD_ZERO;
        head_src <= SRC_FIFO;
      end
    end
  end

  // cycles since the last sample pulse; checks the conversion length without long repetitions
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) conv_age <= 8'h00;
    else if (sample_o) conv_age <= 8'h01;
    else if (conv_age != 8'hFF) conv_age <= conv_age + 8'h01;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_unipolar_clamp: assert property (do_wr && sample_mode_o != IN_BIP && conv_diff_i < 0
    |=> mem[$past(wr_ptr)].code == CODE_ZERO) else $error("unipolar negative not zero");
  a_bipolar_code: assert property (do_wr && sample_mode_o == IN_BIP && conv_diff_i < 0
    && conv_diff_i >= BIP_LO |=> mem[$past(wr_ptr)].code[11]) else $error("bipolar sign lost");
  a_se_unipolar: assert property (sample_o && !cfg.uni[sample_ch_o[3:1]] &&
    !cfg.bip[sample_ch_o[3:1]] && !cfg.pdiff |-> sample_mode_o == IN_SE)
    else $error("single-ended not unipolar");
  a_fifo_overwrite: assert property (do_wr && !do_pop && fifo_count_o == FIFO_FULL && !fifo_rst
    |=> fifo_count_o == FIFO_FULL && rd_ptr == $past(rd_ptr) + 4'h1)
    else $error("full FIFO did not overwrite oldest");
  a_fifo_bound: assert property (fifo_count_o <= FIFO_FULL) else $error("FIFO count over 16");
  a_empty_zero: assert property (!framing && !echo_pend && !external && fifo_count_o == 5'h00
    |=> head == WORD_ZERO) else $error("empty FIFO not zero");
  a_eoc_hold: assert property (!eoc_n_o && !cs_fall && !cnv_fall |=> !eoc_n_o)
    else $error("end flag released early");
  a_eoc_after_scan: assert property (scan_done && !conv_ext |=> !eoc_n_o ##1 state == ST_IDLE)
    else $error("end flag not set after scan");
  a_software_convert_clear: assert property (scan_done && sw_run && !mode_wr && !soft_rst |=> !cfg.software_convert)
    else $error("software convert bit not cleared");
  a_conv_length: assert property ((conv_end |-> conv_age == CONV_CYC) and
    (state == ST_CONV && !sample_o |-> conv_age <= CONV_CYC))
    else $error("conversion length wrong");
  a_ext_next: assert property (conv_end && conv_ext |=> ext_valid)
    else $error("external result not held");
  a_pop_whole: assert property (@(negedge sclk_i) disable iff (!rst_n_i)
    pop_tgl != $past(pop_tgl) |-> $past(out_cnt) == BIT_LAST)
    else $error("pop without full word");

  c_overwrite: cover property (ovw);
  c_echo: cover property (pop_evt && head_src == SRC_ECHO);
  c_software_convert: cover property (scan_done && sw_run);
  c_ext: cover property (pop_evt && head_src == SRC_EXT && head != WORD_ZERO);
endmodule : sar_conv_ctrl

// [sar_conv_pkg.sv]
/*
  Shared constants, types and coding helpers for the SAR conversion and FIFO control.
  Assumes a 50 MHz system clock and a serial host in clock-idles-high mode 3.
*/
// How it works
// - straight binary unipolar, two's complement bipolar
// - unipolar negative input gives code zero
// - single-ended channels always convert unipolar
// - 16 single, 8 pairs, 15 pseudo inputs
// - pseudo common bit references 15 inputs
// - 12-bit result, step is reference over 4096
// - FIFO holds 16 internal results
// - full FIFO overwrites oldest result
// - result is 2 bytes, channel first
// - oldest unread data after chip-select fall
// - empty FIFO reads as zeros
// - external mode samples at chip-select fall
// - channel given this frame, sampled at next frame's start, result read the frame after
// - internal pacing from 13.33 MHz oscillator
// - scan converts all, stores, then flags end
// - end flag low until chip-select/convert start
// - software bit starts delayed scan, then clears
// - echo bit returns configuration next frame
// - tagged word is 4-bit channel, 12-bit result
// - input on rising, output on falling sclk
// - frame starts at chip-select fall, 16 bits
package sar_conv_pkg;
  localparam int          DATA_W     = 12;
  localparam int          WORD_W     = 16;
  localparam int          FIFO_DEPTH = 16;
  localparam longint      CLK_HZ     = 50_000_000;
  localparam longint      OSC_HZ     = 13_330_000;
  localparam longint      CONV_OSC   = 16;
  // conversion length: oscillator cycles scaled to system clock, rounded up
  localparam logic [7:0]  CONV_CYC   = 8'((CONV_OSC * CLK_HZ + OSC_HZ - 1) / OSC_HZ - 1);
  localparam longint      SW_DELAY_NS = 500;
  localparam logic [7:0]  SW_DLY_CYC = 8'((SW_DELAY_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam logic [4:0]  FIFO_FULL  = 5'h10;
  localparam logic [4:0]  BIT_LAST   = 5'h0F;
  localparam logic [4:0]  BIT_DONE   = 5'h10;
  localparam int          REG_SEL_BIT = 15;
  localparam logic [3:0]  ID_CFG     = 4'h0;
  localparam logic [3:0]  ID_UNI     = 4'h1;
  localparam logic [3:0]  ID_BIP     = 4'h2;
  localparam logic [3:0]  SCAN_MANUAL = 4'h1;
  localparam logic [3:0]  COMMON_CH  = 4'hF;
  localparam logic [1:0]  RST_FIFO   = 2'h1;
  localparam logic [1:0]  RST_ALL    = 2'h2;
  localparam int          SOFTWARE_CONVERT_BIT  = 1;
  localparam int          TAG_BIT    = 2;
  localparam int          ECHO_BIT   = 2;
  localparam int          PDIFF_BIT  = 2;
  localparam logic [3:0]  SYNC_RST   = 4'hC;
  localparam logic signed [12:0] BIP_HI = 13'sh07FF;
  localparam logic signed [12:0] BIP_LO = 13'sh1800;
  localparam logic [11:0] CODE_BIP_MAX = 12'h7FF;
  localparam logic [11:0] CODE_BIP_MIN = 12'h800;
  localparam logic [11:0] CODE_ZERO    = 12'h000;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;

  typedef enum logic [1:0] {IN_SE = 2'h0, IN_UNI = 2'h1, IN_BIP = 2'h2, IN_PSEUDO = 2'h3}
    in_mode_e;
  typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_ECHO = 2'h1, SRC_FIFO = 2'h2, SRC_EXT = 2'h3}
    src_e;
  typedef struct packed {
    logic [3:0]  ch;
    logic [11:0] code;
  } result_s;
  typedef struct packed {
    logic [3:0] scan;
    logic [3:0] last_ch;
    logic       software_convert;
    logic       tag;
    logic [7:0] uni;
    logic [7:0] bip;
    logic       pdiff;
  } cfg_s;
  localparam cfg_s CFG_RST = '{scan: SCAN_MANUAL, last_ch: 4'h0, software_convert: 1'b0, tag: 1'b0,
                               uni: 8'h00, bip: 8'h00, pdiff: 1'b0};

  // pairs set bipolar win over unipolar; channel 15 is the shared common in pseudo mode
  function automatic in_mode_e in_mode(input logic [3:0] ch, input cfg_s c);
    if (c.bip[ch[3:1]]) return IN_BIP;
    if (c.uni[ch[3:1]]) return IN_UNI;
    if (c.pdiff && ch != COMMON_CH) return IN_PSEUDO;
    return IN_SE;
  endfunction : in_mode

  function automatic logic [11:0] code_of(input logic signed [12:0] d, input in_mode_e m);
    if (m == IN_BIP) begin
      if (d > BIP_HI) return CODE_BIP_MAX;
      if (d < BIP_LO) return CODE_BIP_MIN;
      return d[11:0];
    end
    if (d < 0) return CODE_ZERO;
    return d[11:0];
  endfunction : code_of
endpackage : sar_conv_pkg

// [spi_host_model.sv]
/*
  Serial host model: clock-idles-high frames on cs/sclk/din and the convert-start pulse.
  Assumes the bench starts each call just after its own clock edge; sclk runs in frames only.
*/
`timescale 1ns/1ns
module spi_host_model (
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o,
  output logic      convert_start_n_o,
  input  wire logic dout_i
);
  initial begin
    cs_n_o            = 1'h1;
    sclk_o            = 1'h1;
    din_o             = 1'h0;
    convert_start_n_o = 1'h1;
  end

  // 64 ns sclk; 17 cycles keep chip select low past the software-convert minimum
  task automatic frame(input logic [15:0] wr, input int nbits, output logic [15:0] rd);
    rd     = 16'h0000;
    cs_n_o = 1'h0;
    #70;
    for (int k = 0; k < nbits; k++) begin
      sclk_o = 1'h0;
      din_o  = (k < 16) ? wr[15 - k] : ~din_o;
      #32;
      sclk_o = 1'h1;
      if (k < 16) rd[15 - k] = dout_i;
      #32;
    end
    #25;
    cs_n_o = 1'h1;
    // no pull on din, so a released line toggles rather than keeping its last bit
    din_o  = ~din_o;
    #200;
  endtask : frame

  // held three clk periods so the two-flop synchroniser cannot miss it
  task automatic pulse_start();
    convert_start_n_o = 1'h0;
    #60;
    convert_start_n_o = 1'h1;
  endtask : pulse_start
endmodule : spi_host_model

// [test_sar_adc_conversion_fifo_control.sv]
/*
  Self-checking bench for the conversion control: internal scans into the FIFO, echo,
  software convert and external mode. Assumes spi_host_model and the design package.
*/
`timescale 1ns/1ns
module test_sar_adc_conversion_fifo_control
  import sar_conv_pkg::*;
;
  logic               clk_i = 1'h0;
  logic               rst_n_i = 1'h0;
  logic               sclk, cs_n, din, cnv_n, dout, dout_oe, dout_line, eoc_n, smp;
  logic signed [12:0] diff = 13'h0, nd;
  logic [3:0]         smp_ch, exp_ch = 4'h0, last_ch = 4'h0;
  in_mode_e           smp_mode;
  logic [4:0]         fcount;
  logic [7:0]         uni_m = 8'h00, bip_m = 8'h00;
  logic               pdiff_m = 1'h0, internal_m = 1'h0;
  logic [15:0]        r, e;
  result_s            exp_q[$];
  result_s            last_res;
  time                t_rise, t_first;
  int                 miscompares = 0, check_count = 0, smp_seen = 0, n0;

  always #10 clk_i = ~clk_i;
  // an undriven data line reads as unknown and so never matches
  assign dout_line = (dout_oe === 1'h1) ? dout : 1'hx;

  sar_conv_ctrl i_sar_conv_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .convert_start_n_i(cnv_n), .conv_diff_i(diff), .dout_o(dout), .dout_oe_o(dout_oe),
    .eoc_n_o(eoc_n), .sample_o(smp), .sample_ch_o(smp_ch), .sample_mode_o(smp_mode),
    .fifo_count_o(fcount));
  spi_host_model i_spi_host (
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .convert_start_n_o(cnv_n),
    .dout_i(dout_line));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  function automatic in_mode_e exp_mode(input logic [3:0] ch);
    if (bip_m[ch[3:1]]) return IN_BIP;
    if (uni_m[ch[3:1]]) return IN_UNI;
    if (pdiff_m && ch != COMMON_CH) return IN_PSEUDO;
    return IN_SE;
  endfunction : exp_mode

  function automatic logic [11:0] exp_code(input logic signed [12:0] d, input in_mode_e m);
    if (m == IN_BIP) return (d > 13'sh7FF) ? 12'h7FF : (d < 13'sh1800) ? 12'h800 : d[11:0];
    return (d < 13'sh0) ? 12'h000 : d[11:0];
  endfunction : exp_code

  function automatic logic [15:0] mode_w(input logic [3:0] scan, input logic [3:0] ch,
                                         input logic [1:0] rs, input logic tag, input logic sw);
    return {1'h0, scan, ch, rs, 2'h0, tag, sw, 1'h0};
  endfunction : mode_w

  // each full frame in internal mode hands out the head result, or zeros when empty
  task automatic xfer(input logic [15:0] w);
    logic [15:0] got, want;
    want = 16'h0000;
    if (internal_m && exp_q.size() > 0) want = exp_q.pop_front();
    @(posedge clk_i);
    #2;
    i_spi_host.frame(w, 17, got);
    if (internal_m) check("fifo_word", got, want);
  endtask : xfer

  task automatic wait_eoc();
    int n;
    n = 0;
    while (eoc_n !== 1'h0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check("eoc_low", {15'h0, eoc_n}, 16'h0000);
  endtask : wait_eoc

  always @(posedge cs_n) t_rise = $time;

  // analog side: a fresh random difference per conversion, expected code worked out here
  always @(posedge clk_i) begin
    if (smp === 1'h1) begin
      check("sample_ch", {12'h0, smp_ch}, {12'h0, exp_ch});
      check("sample_mode", {14'h0, smp_mode}, {14'h0, exp_mode(exp_ch)});
      nd = 13'($urandom_range(0, 8191));
      last_res = '{ch: exp_ch, code: exp_code(nd, exp_mode(exp_ch))};
      diff <= #2 nd;
      smp_seen++;
      if (internal_m) begin
        if (exp_ch == 4'h0) t_first = $time;
        if (exp_q.size() == 16) void'(exp_q.pop_front());
        exp_q.push_back(last_res);
        exp_ch++;
      end
    end
  end

  initial begin
    #1_500_000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hDD6003E3));
    repeat (5) @(posedge clk_i);
    check("rst_eoc", {15'h0, eoc_n}, 16'h0001);
    check("rst_count", {11'h0, fcount}, 16'h0000);
    @(posedge clk_i);
    #2 rst_n_i = 1'h1;
    repeat (4) @(posedge clk_i);
    xfer(mode_w(4'h2, 4'h0, 2'h1, 1'h1, 1'h0));
    internal_m = 1'h1;
    xfer(16'h8004);
    @(posedge clk_i);
    #2;
    i_spi_host.frame(16'h8000, 17, r);
    check("echo", r, 16'h8004);
    xfer(16'h8000);
    for (int k = 0; k < 3; k++) begin
      bip_m   = 8'($urandom);
      uni_m   = 8'($urandom);
      pdiff_m = 1'($urandom);
      last_ch = (k == 0) ? 4'($urandom_range(1, 14)) : 4'hF;
      xfer({5'h12, bip_m, 3'h0});
      xfer({5'h11, uni_m, pdiff_m, 2'h0});
      xfer(mode_w(4'h2, last_ch, 2'h0, 1'h1, 1'(k == 2)));
      exp_ch = 4'h0;
      if (k < 2) begin
        @(posedge clk_i);
        #2;
        i_spi_host.pulse_start();
      end
      wait_eoc();
      n0 = int'((t_first - t_rise) / 20);
      if (k == 2) check("sw_delay", 16'(n0 >= 25 && n0 <= 34), 16'h0001);
      repeat (10) @(posedge clk_i);
      check("eoc_hold", {15'h0, eoc_n}, 16'h0000);
      check("fifo_count", {11'h0, fcount}, 16'(exp_q.size()));
      if (k == 0) begin
        @(posedge clk_i);
        #2;
        i_spi_host.frame(16'h8000, 8, r);
        check("partial", {r[15:8], 8'h00}, {exp_q[0][15:8], 8'h00});
      end
      xfer(16'h8000);
      check("eoc_release", {15'h0, eoc_n}, 16'h0001);
      while (k != 1 && exp_q.size() > 0) xfer(16'h8000);
    end
    n0 = smp_seen;
    xfer(16'h8000);
    repeat (60) @(posedge clk_i);
    check("sw_cleared", 16'(smp_seen - n0), 16'h0000);
    internal_m = 1'h0;
    xfer(mode_w(4'h1, 4'h0, 2'h2, 1'h1, 1'h0));
    {uni_m, bip_m, pdiff_m} = 17'h0;
    last_ch = 4'h0;
    // tag goes off with frame 3's word; frame 0 returns the external result held since the first frame, so it goes unchecked
    for (int j = 0; j < 6; j++) begin
      e = (j < 4) ? {last_res.ch, last_res.code} : {1'h0, last_res.code, 3'h0};
      exp_ch = last_ch;
      last_ch = 4'($urandom);
      @(posedge clk_i);
      #2;
      i_spi_host.frame(mode_w(4'h1, last_ch, 2'h0, 1'(j < 3), 1'h0), 17, r);
      if (j >= 1) check("ext_word", r, e);
      repeat (20) @(posedge clk_i);
    end
    check("idle_oe", {15'h0, dout_oe}, 16'h0000);
    report_and_stop();
  end
endmodule : test_sar_adc_conversion_fifo_control
